// [src/emr_pkg.sv]
// constants, register map and field layout of the interrupt, management and filter register block
package emr_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h28;
  localparam logic [7:0] OFS_IRQ_DISABLE = 8'h2C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h30;
  localparam logic [7:0] OFS_PHY_MAINT = 8'h34;
  localparam logic [7:0] OFS_PAUSE_TIME = 8'h38;
  localparam logic [7:0] OFS_HASH_LOW = 8'h90;
  localparam logic [7:0] OFS_HASH_HIGH = 8'h94;
  localparam logic [7:0] OFS_MATCH1_LOW = 8'h98;
  localparam logic [7:0] OFS_MATCH1_HIGH = 8'h9C;
  localparam logic [7:0] OFS_MATCH2_LOW = 8'hA0;
  localparam logic [7:0] OFS_MATCH2_HIGH = 8'hA4;

  // ----------------------------------------------------------------
  // interrupt source layout, shared by status, enable, disable, mask
  // ----------------------------------------------------------------
  localparam int IRQ_W = 14;
  localparam int BIT_MANAGEMENT_DONE = 0;
  localparam int BIT_RECEIVE_COMPLETE = 1;
  localparam int BIT_RECEIVE_USED_BIT_SEEN = 2;
  localparam int BIT_TRANSMIT_USED_BIT_SEEN = 3;
  localparam int BIT_TRANSMIT_UNDERRUN = 4;
  localparam int BIT_RETRY_LIMIT_HIT = 5;
  localparam int BIT_TRANSMIT_ERROR = 6;
  localparam int BIT_TRANSMIT_COMPLETE = 7;
  localparam int BIT_RECEIVE_OVERRUN = 10;
  localparam int BIT_BUS_ERROR = 11;
  localparam int BIT_PAUSE_RECEIVED = 12;
  localparam int BIT_PAUSE_ZERO = 13;
  localparam logic [IRQ_W-1:0] IRQ_VALID = 14'h3CFF;
  localparam logic [IRQ_W-1:0] MASK_RESET = 14'h3CFF;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // phy maintenance fields
  // ----------------------------------------------------------------
  localparam int MAINT_SOF_LSB = 30;
  localparam int MAINT_OP_LSB = 28;
  localparam int MAINT_DATA_W = 16;
  localparam logic [1:0] SOF_VALID = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int BIT_TIME_NS = 10;
  localparam int PAUSE_QUANTUM_BITS = 512;
  localparam int PAUSE_TICK_CYCLES = (PAUSE_QUANTUM_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MDC_HALF_PERIOD_NS = 200;
  localparam int MDC_HALF_CYCLES = (MDC_HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PREAMBLE_BITS = 32;
  localparam int FRAME_BITS = 64;
  localparam int TURNAROUND_BIT = 46;
  localparam int READ_DATA_BIT = 48;

  typedef enum logic {MDIO_IDLE, MDIO_RUN} emr_mdio_state_type;
endpackage

// [src/emr_mdio_shifter.sv]
// serial management frame engine: preamble, frame bits out, read data in
`timescale 1ns/10ps
`default_nettype none
module emr_mdio_shifter #(
  parameter int HALF_CYCLES = emr_pkg::MDC_HALF_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [31:0] frame,
  input wire logic is_read,
  input wire logic mdio_in,
  output logic mdc,
  output logic mdio_out,
  output logic mdio_oe,
  output logic done,
  output logic [15:0] read_data
);
  import emr_pkg::*;

  typedef struct packed {
    emr_mdio_state_type state;
    logic [7:0] div;
    logic mdc;
    logic [5:0] bitcnt;
    logic [31:0] shreg;
    logic mdio_o;
    logic oe;
    logic rd;
    logic [15:0] rdata;
    logic done;
  } emr_shift_type;

  emr_shift_type s_q;
  emr_shift_type s_d;
  logic [5:0] idx;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    idx = s_q.bitcnt + 6'd1;
    case (s_q.state)
      MDIO_IDLE: begin
        s_d.mdc = 1'b0;
        s_d.oe = 1'b0;
        if (start) begin // RULE18
          s_d.state = MDIO_RUN;
          s_d.shreg = frame; // RULE8 RULE10
          s_d.rd = is_read;
          s_d.bitcnt = 6'd0;
          s_d.div = 8'h00;
          s_d.oe = 1'b1;
          s_d.mdio_o = 1'b1;
        end
      end
      MDIO_RUN: begin
        if (s_q.div == 8'(HALF_CYCLES - 1)) begin
          s_d.div = 8'h00;
          s_d.mdc = ~s_q.mdc;
          if (!s_q.mdc) begin
            // the phy drives read data after the falling edge, so sample at the rising edge here
            if (s_q.rd && s_q.bitcnt >= 6'(READ_DATA_BIT)) begin
              s_d.rdata = {s_q.rdata[14:0], mdio_in}; // RULE18
            end
          end else if (s_q.bitcnt == 6'(FRAME_BITS - 1)) begin
            s_d.state = MDIO_IDLE;
            s_d.oe = 1'b0;
            s_d.done = 1'b1;
          end else begin
            s_d.bitcnt = idx;
            if (idx >= 6'(PREAMBLE_BITS)) begin
              s_d.mdio_o = s_q.shreg[31];
              s_d.shreg = {s_q.shreg[30:0], 1'b0};
            end
            // release the line from the turnaround on for reads
            s_d.oe = !(s_q.rd && idx >= 6'(TURNAROUND_BIT));
          end
        end else begin
          s_d.div = s_q.div + 8'h01;
        end
      end
      default: begin
        s_d.state = MDIO_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mdc = s_q.mdc;
  assign mdio_out = s_q.mdio_o;
  assign mdio_oe = s_q.oe;
  assign done = s_q.done;
  assign read_data = s_q.rdata;
endmodule
`default_nettype wire

// [src/emr_top.sv]
// interrupt control, phy maintenance, pause countdown and address filter registers on ahb-lite
// Operation
// RULE1: disable write of one masks that source
// RULE2: mask register shows which sources are masked
// RULE3: enable write of one unmasks that source
// RULE4: enable, disable, mask share one bit layout
// RULE5: software puts start pattern 01 on top
// RULE6: operation 10 reads, 01 writes, else invalid
// RULE7: turnaround field written 10, read back unchanged
// RULE8: phy write sends the data field
// RULE9: phy read result loads the data field
// RULE10: phy and register address select target
// RULE11: pause count decrements every 512 bit times
// RULE12: low hash register gives filter bits 31:0
// RULE13: high hash register gives bits 63:32
// RULE14: match low register holds address bits 31:0
// RULE15: match high register holds bits 47:32
// RULE16: management done flag set, cleared by read
// RULE17: pause zero flag set, cleared by read
// RULE18: maintenance write starts frame, read captures data
`timescale 1ns/10ps
`default_nettype none
module emr_top #(
  parameter int PAUSE_TICKS = emr_pkg::PAUSE_TICK_CYCLES,
  parameter int MDC_HALF = emr_pkg::MDC_HALF_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic [emr_pkg::IRQ_W-1:0] event_pulse,
  input wire logic pause_frame_valid,
  input wire logic [15:0] pause_frame_quantum,
  output logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  output logic [63:0] hash_filter,
  output logic [47:0] match_addr1,
  output logic [47:0] match_addr2,
  output logic pause_active
);
  import emr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ready;
    logic [31:0] rdata;
    logic irq;
    logic wr_pend;
    logic rd_pend;
    logic [ADDR_W-1:0] addr;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic [31:0] maint;
    logic mbusy;
    logic mstart;
    logic [15:0] pause;
    logic [15:0] tick;
    logic pause_on;
    logic [63:0] hash;
    logic [47:0] match1;
    logic [47:0] match2;
  } emr_regs_type;

  emr_regs_type r_q;
  emr_regs_type r_d;

  logic accept;
  logic m_done;
  logic [15:0] m_rdata;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic [1:0] w_sof;
  logic [1:0] w_op;

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a, input emr_regs_type r);
    logic [31:0] v;
    v = REG_RESET;
    case (a)
      OFS_STATUS: v = {18'h00000, r.status};
      OFS_IRQ_MASK: v = {18'h00000, r.mask}; // RULE2
      OFS_PHY_MAINT: v = r.maint; // RULE7 RULE9
      OFS_PAUSE_TIME: v = {16'h0000, r.pause};
      OFS_HASH_LOW: v = r.hash[31:0];
      OFS_HASH_HIGH: v = r.hash[63:32];
      OFS_MATCH1_LOW: v = r.match1[31:0];
      OFS_MATCH1_HIGH: v = {16'h0000, r.match1[47:32]};
      OFS_MATCH2_LOW: v = r.match2[31:0];
      OFS_MATCH2_HIGH: v = {16'h0000, r.match2[47:32]};
      default: v = REG_RESET;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.mstart = 1'b0;
    accept = hsel && htrans[1] && hready;
    ev = event_pulse & IRQ_VALID;
    clr = '0;
    w_sof = hwdata[MAINT_SOF_LSB +: 2];
    w_op = hwdata[MAINT_OP_LSB +: 2];

    // address phase; every read takes one wait state so that the
    // previous write's data phase has landed before the mux samples
    r_d.wr_pend = accept && hwrite;
    r_d.rd_pend = accept && !hwrite;
    r_d.ready = !(accept && !hwrite);
    if (accept) begin
      r_d.addr = haddr[ADDR_W-1:0];
    end

    // management frame completion
    if (m_done) begin
      r_d.mbusy = 1'b0;
      ev[BIT_MANAGEMENT_DONE] = 1'b1; // RULE16
      if (r_q.maint[MAINT_OP_LSB +: 2] == OP_READ) begin
        r_d.maint[MAINT_DATA_W-1:0] = m_rdata; // RULE9
      end
    end

    // pause countdown, one step per 512 bit times
    if (r_q.pause != 16'h0000) begin
      if (r_q.tick == 16'(PAUSE_TICKS - 1)) begin
        r_d.tick = 16'h0000;
        r_d.pause = r_q.pause - 16'h0001; // RULE11
        if (r_q.pause == 16'h0001) begin
          ev[BIT_PAUSE_ZERO] = 1'b1; // RULE17
        end
      end else begin
        r_d.tick = r_q.tick + 16'h0001;
      end
    end
    if (pause_frame_valid) begin
      r_d.pause = pause_frame_quantum;
      r_d.tick = 16'h0000;
      ev[BIT_PAUSE_RECEIVED] = 1'b1;
    end

    // data phase of a write
    if (r_q.wr_pend) begin
      case (r_q.addr)
        OFS_IRQ_ENABLE: r_d.mask = r_q.mask & ~(hwdata[IRQ_W-1:0] & IRQ_VALID); // RULE3 RULE4
        OFS_IRQ_DISABLE: r_d.mask = r_q.mask | (hwdata[IRQ_W-1:0] & IRQ_VALID); // RULE1 RULE4
        OFS_PHY_MAINT: begin
          // a write while a frame is on the wire is dropped to keep the frame intact
          if (!r_q.mbusy) begin
            r_d.maint = hwdata; // RULE7 RULE10
            if (w_sof == SOF_VALID && (w_op == OP_READ || w_op == OP_WRITE)) begin // RULE5 RULE6
              r_d.mstart = 1'b1; // RULE18
              r_d.mbusy = 1'b1;
            end else begin
              // invalid frame: nothing goes out, but software still sees completion
              ev[BIT_MANAGEMENT_DONE] = 1'b1; // RULE6
            end
          end
        end
        OFS_PAUSE_TIME: begin
          r_d.pause = hwdata[15:0];
          r_d.tick = 16'h0000;
        end
        OFS_HASH_LOW: r_d.hash[31:0] = hwdata; // RULE12
        OFS_HASH_HIGH: r_d.hash[63:32] = hwdata; // RULE13
        OFS_MATCH1_LOW: r_d.match1[31:0] = hwdata; // RULE14
        OFS_MATCH1_HIGH: r_d.match1[47:32] = hwdata[15:0]; // RULE15
        OFS_MATCH2_LOW: r_d.match2[31:0] = hwdata; // RULE14
        OFS_MATCH2_HIGH: r_d.match2[47:32] = hwdata[15:0]; // RULE15
        // unmapped and read-only offsets: the write is dropped, and a
        // management result landing in this same cycle must not be lost
        default: begin
        end
      endcase
    end

    // data phase of a read: capture, and clear status on its read
    if (r_q.rd_pend) begin
      r_d.rdata = read_mux(r_q.addr, r_q);
      if (r_q.addr == OFS_STATUS) begin
        clr = IRQ_VALID; // RULE16 RULE17
      end
    end

    // an event in the clearing cycle survives the clear
    r_d.status = ((r_q.status & ~clr) | ev) & IRQ_VALID;
    r_d.irq = |(r_d.status & ~r_d.mask);
    r_d.pause_on = r_d.pause != 16'h0000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_q <= '0;
      r_q.ready <= 1'b1;
      r_q.mask <= MASK_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // management link
  // ----------------------------------------------------------------
  emr_mdio_shifter #(
    .HALF_CYCLES(MDC_HALF)
  ) u_mdio (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(r_q.mstart),
    .frame(r_q.maint),
    .is_read(r_q.maint[MAINT_OP_LSB +: 2] == OP_READ),
    .mdio_in(mdio_in),
    .mdc(mdc),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .done(m_done),
    .read_data(m_rdata)
  );

  assign hreadyout = r_q.ready;
  assign hresp = 1'b0;
  assign hrdata = r_q.rdata;
  assign irq = r_q.irq;
  assign hash_filter = r_q.hash;
  assign match_addr1 = r_q.match1;
  assign match_addr2 = r_q.match2;
  assign pause_active = r_q.pause_on;
endmodule
`default_nettype wire

// [tb/emr_top_chk.sv]
// concurrent checks on the register block's bus, interrupt, management and filter ports
`timescale 1ns/10ps
`default_nettype none
module emr_top_chk
  import emr_pkg::*;
#(
  parameter int PAUSE_TICKS = 640,
  parameter int MDC_HALF = 25
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic irq,
  input wire logic pause_frame_valid,
  input wire logic [15:0] pause_frame_quantum,
  input wire logic mdc,
  input wire logic [63:0] hash_filter,
  input wire logic [47:0] match_addr1,
  input wire logic pause_active
);
  import emr_pkg::*;
  localparam int PT_HI = PAUSE_TICKS + 1;
  logic acc;
  logic wr_q;
  logic [7:0] wa_q;
  logic [7:0] hi_q;
  assign acc = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      hi_q <= 8'h00;
    end else begin
      wr_q <= acc && hwrite;
      wa_q <= haddr[7:0];
      hi_q <= mdc ? hi_q + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_read_wait;
    acc && !hwrite |=> s_one_wait;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
  property p_disable_all;
    wr_q && wa_q == OFS_IRQ_DISABLE && hwdata[13:0] == IRQ_VALID |=> !irq;
  endproperty
  a_disable_all: assert property (p_disable_all) else $error("irq after full disable");
  property p_hash_low;
    wr_q && wa_q == OFS_HASH_LOW |=> hash_filter[31:0] == $past(hwdata);
  endproperty
  a_hash_low: assert property (p_hash_low) else $error("hash low not loaded");
  property p_hash_high;
    wr_q && wa_q == OFS_HASH_HIGH |=> hash_filter[63:32] == $past(hwdata);
  endproperty
  a_hash_high: assert property (p_hash_high) else $error("hash high not loaded");
  property p_match_low;
    wr_q && wa_q == OFS_MATCH1_LOW |=> match_addr1[31:0] == $past(hwdata);
  endproperty
  a_match_low: assert property (p_match_low) else $error("match low not loaded");
  property p_match_high;
    wr_q && wa_q == OFS_MATCH1_HIGH |=> match_addr1[47:32] == $past(hwdata[15:0]);
  endproperty
  a_match_high: assert property (p_match_high) else $error("match high not loaded");
  property p_pause_load;
    pause_frame_valid && pause_frame_quantum != 16'h0000 && !wr_q |=> pause_active;
  endproperty
  a_pause_load: assert property (p_pause_load) else $error("pause not started");
  // a count of one must end after one tick, neither at once nor late
  property p_pause_one;
    pause_frame_valid && pause_frame_quantum == 16'h0001 && !wr_q |=> pause_active[*2] ##[1:PT_HI] !pause_active;
  endproperty
  a_pause_one: assert property (p_pause_one) else $error("pause tick length wrong");
  property p_mdc_half;
    $fell(mdc) |-> hi_q == 8'(MDC_HALF);
  endproperty
  a_mdc_half: assert property (p_mdc_half) else $error("mdc high time wrong");
endmodule
bind emr_top emr_top_chk #(.PAUSE_TICKS(PAUSE_TICKS), .MDC_HALF(MDC_HALF)) i_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .irq(irq), .pause_frame_valid(pause_frame_valid), .pause_frame_quantum(pause_frame_quantum),
  .mdc(mdc), .hash_filter(hash_filter), .match_addr1(match_addr1), .pause_active(pause_active));
`default_nettype wire

// [tb/emr_phy_model.sv]
// behavioural phy on the management link: records frames and answers reads
`timescale 1ns/10ps
`default_nettype none
module emr_phy_model #(
  parameter logic [15:0] RD_DATA = 16'hA5C3
) (
  input wire logic mdc,
  input wire logic mdio,
  input wire logic mdio_oe,
  output logic phy_oe,
  output logic phy_bit,
  output logic [31:0] frame_seen,
  output int n_frames
);
  logic [63:0] sr = 64'h0;
  logic [5:0] cnt = 6'h00;
  initial begin
    phy_oe = 1'b0;
    phy_bit = 1'b0;
    frame_seen = 32'h0;
    n_frames = 0;
  end
  always @(posedge mdc) begin
    sr <= {sr[62:0], mdio};
    cnt <= cnt + 6'h01;
    if (cnt == 6'h3F) begin
      frame_seen <= {sr[30:0], mdio};
      n_frames <= n_frames + 1;
    end
  end
  // on a read we own the line from the second turnaround bit, driven low, through the 16 data bits;
  // the pull-up owns it otherwise
  always @(negedge mdc) begin
    phy_oe <= !mdio_oe && cnt >= 6'h2F;
    phy_bit <= (cnt >= 6'h30) ? RD_DATA[4'(6'h3F - cnt)] : 1'b0;
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the interrupt, management, pause and filter registers
`timescale 1ns/10ps
`default_nettype none
module tb;
  import emr_pkg::*;
  localparam int PT = 4;
  localparam logic [15:0] RD_DATA = 16'hA5C3;
  logic hclk, hreadyout, hresp, irq, mdc, mdio_out, mdio_oe, pause_active, mdio_w, phy_oe, phy_bit;
  logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pause_frame_valid = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, frame_seen, mw;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [IRQ_W-1:0] event_pulse = '0;
  logic [15:0] pause_frame_quantum = 16'h0;
  logic [63:0] hash_filter;
  logic [47:0] match_addr1, match_addr2;
  logic [31:0] pat [5] = '{32'h8421_C3A5, 32'h1357_9BDF, 32'hFEDC_BA98, 32'h5A5A_F00F, 32'h7E81_42BD};
  logic [31:0] bad [3] = '{32'h4002_1111, 32'h7002_1111, 32'h1002_1111};
  int mismatches = 0, n_tests = 0, n_frames, n, nf;
  // open-drain style line: whoever enables drives, the pull-up wins otherwise
  assign mdio_w = mdio_oe ? mdio_out : (phy_oe ? phy_bit : 1'b1);
  emr_top #(.PAUSE_TICKS(PT), .MDC_HALF(2)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq), .event_pulse(event_pulse), .pause_frame_valid(pause_frame_valid),
    .pause_frame_quantum(pause_frame_quantum), .mdc(mdc), .mdio_in(mdio_w), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .hash_filter(hash_filter), .match_addr1(match_addr1), .match_addr2(match_addr2), .pause_active(pause_active));
  emr_phy_model #(.RD_DATA(RD_DATA)) i_phy (.mdc(mdc), .mdio(mdio_w), .mdio_oe(mdio_oe), .phy_oe(phy_oe),
    .phy_bit(phy_bit), .frame_seen(frame_seen), .n_frames(n_frames));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    if (!w) chk(hrdata, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(a, 1'b0, e);
  endtask
  task automatic phy_maintenance(input logic [31:0] w, input logic [31:0] e);
    nf = n_frames;
    wr(OFS_PHY_MAINT, w);
    n = 0;
    while (!irq && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    rd(OFS_STATUS, 32'h1);
    rd(OFS_PHY_MAINT, e);
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFS_IRQ_MASK, {18'h0, MASK_RESET});
    rd(OFS_IRQ_ENABLE, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0);
    wr(OFS_IRQ_MASK, 32'h0);
    for (int i = 0; i < 5; i++) wr(OFS_HASH_LOW + 8'(4 * i), pat[i]);
    for (int i = 0; i < 5; i++) rd(OFS_HASH_LOW + 8'(4 * i), i == 3 ? {16'h0, pat[3][15:0]} : pat[i]);
    chk(hash_filter[31:0], pat[0]);
    chk(hash_filter[63:32], pat[1]);
    chk(match_addr1[31:0], pat[2]);
    chk({16'h0, match_addr1[47:32]}, {16'h0, pat[3][15:0]});
    chk(match_addr2[31:0], pat[4]);
    wr(OFS_MATCH2_HIGH, pat[1]);
    rd(OFS_MATCH2_HIGH, {16'h0, pat[1][15:0]});
    chk({16'h0, match_addr2[47:32]}, {16'h0, pat[1][15:0]});
    chk({31'h0, hresp}, 32'h0);
    for (int k = 0; k < IRQ_W; k++) begin
      if (IRQ_VALID[k]) begin
        event_pulse <= 14'h0001 << k;
        @(posedge hclk);
        event_pulse <= '0;
        @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_ENABLE, 32'h1 << k);
        rd(OFS_IRQ_MASK, {18'h0, MASK_RESET} & ~(32'h1 << k));
        chk({31'h0, irq}, 32'h1);
        rd(OFS_STATUS, 32'h1 << k);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_DISABLE, 32'h1 << k);
        rd(OFS_IRQ_MASK, {18'h0, MASK_RESET});
      end
    end
    wr(OFS_IRQ_DISABLE, 32'h0);
    wr(OFS_IRQ_ENABLE, 32'h0000_3301);
    rd(OFS_IRQ_MASK, 32'h0000_0CFE);
    mw = {SOF_VALID, OP_WRITE, 5'h0B, 5'h13, 2'h2, 16'hBEEF};
    phy_maintenance(mw, mw);
    chk(frame_seen, mw);
    chk(32'(n_frames), 32'(nf + 1));
    mw = {SOF_VALID, OP_READ, 5'h05, 5'h1F, 2'h2, 16'h0000};
    phy_maintenance(mw, {mw[31:16], RD_DATA});
    chk({16'h0, frame_seen[31:16]}, {16'h0, mw[31:16]});
    chk({16'h0, frame_seen[15:0]}, {16'h0, RD_DATA});
    for (int j = 0; j < 3; j++) begin
      phy_maintenance(bad[j], bad[j]);
      chk(32'(n_frames), 32'(nf));
    end
    wr(OFS_PAUSE_TIME, 32'h3);
    @(posedge hclk);
    n = 0;
    while (pause_active && n < 100) begin
      @(posedge hclk);
      n++;
    end
    chk(32'(n >= 3 * PT - 3 && n <= 3 * PT + 1), 32'h1);
    rd(OFS_STATUS, 32'h0000_2000);
    wr(OFS_PAUSE_TIME, 32'h0);
    repeat (3 * PT) @(posedge hclk);
    rd(OFS_STATUS, 32'h0);
    pause_frame_quantum <= 16'h0001;
    pause_frame_valid <= 1'b1;
    @(posedge hclk);
    pause_frame_valid <= 1'b0;
    repeat (2 * PT) @(posedge hclk);
    rd(OFS_STATUS, 32'h0000_3000);
    rd(OFS_PAUSE_TIME, 32'h0);
    wr(OFS_IRQ_DISABLE, 32'h0000_3CFF);
    rd(OFS_IRQ_MASK, {18'h0, MASK_RESET});
    print_verdict();
  end
endmodule
`default_nettype wire
